/* gdsp_port.sv */
// serial command port with power, enable and calibration register
//
// Operation
// - serial input sampled on each falling serial clock edge while selected
// - select rising edge moves word into register named by top bits
// - first rising serial clock edge loads status into output shifter
// - beyond sixteen bits, earlier received bits shift out in order
// - words travel most significant bit first both ways
// - transfers not a whole multiple of sixteen bits are discarded
// - three address bits select one of eight register codes
// - bit zero enables gauge 0 driver, bit one gauge 1
// - both enables zero puts the device into standby
// - calibration bit measures select pulse and trims oscillator
// - calibration only when each gauge is disabled or stationary
// - frequency select chooses below-target or centred calibration
// - slowdown bit slows oscillator by one third
// - slowed mode needs longer pulse; bad pulse sets fault status
// - null command bit makes the word a pure status read
// - power/enable/calibration fields cannot be read back
// - select high ignores data, output undriven; clock falls still toggle tgl_q and clear ok_q
// - serial output changes on rising serial clock edge
`timescale 1ns/1ps
module gdsp_port #(
  parameter logic [gdsp_pkg::CNT_W-1:0] CAL_LO = gdsp_pkg::CAL_LO,
  parameter logic [gdsp_pkg::CNT_W-1:0] CAL_HI = gdsp_pkg::CAL_HI,
  parameter logic [gdsp_pkg::CNT_W-1:0] CAL_SLOW_LO = gdsp_pkg::CAL_SLOW_LO,
  parameter logic [gdsp_pkg::CNT_W-1:0] CAL_SLOW_HI = gdsp_pkg::CAL_SLOW_HI,
  parameter logic [gdsp_pkg::CNT_W-1:0] CAL_WAIT = gdsp_pkg::CAL_WAIT
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic [gdsp_pkg::WORD_W-1:0] status_i,
  output gdsp_pkg::gdsp_word_t wr_o,
  output logic wr_valid_o,
  output logic gauge0_driver_enable_o,
  output logic gauge1_driver_enable_o,
  output logic standby_o,
  output logic osc_slowdown_o,
  output logic cal_frequency_select_o,
  output logic cal_busy_o,
  output logic cal_fault_status_o,
  output logic [gdsp_pkg::CNT_W-1:0] osc_trim_o
);

  // ---------------- link side, on the serial clock ----------------
  logic link_clr;
  logic [gdsp_pkg::WORD_W-1:0] in_q;
  logic [3:0] fcnt_q;
  logic started_q;
  logic tgl_q;
  logic ok_q;
  logic [gdsp_pkg::WORD_W-1:0] hold_q;
  logic [4:0] rcnt_q;
  logic [gdsp_pkg::WORD_W-1:0] st_q;
  logic so_q;
  logic [gdsp_pkg::WORD_W-1:0] snap_q;
  logic [gdsp_pkg::WORD_W-1:0] in_d;
  logic word_end;

  // select high holds link logic cleared, except tgl_q, ok_q and hold_q
  assign link_clr = cs_n_i | ~reset_n_i;
  // msb enters first, ends up on top
  assign in_d = {in_q[gdsp_pkg::WORD_W-2:0], si_i};
  assign word_end = (fcnt_q == gdsp_pkg::LAST_BIT);

  always_ff @(negedge sclk_i or posedge link_clr) begin
    if (link_clr) begin
      in_q <= '0;
      fcnt_q <= '0;
      started_q <= 1'b0;
    end else begin
      in_q <= in_d;
      fcnt_q <= fcnt_q + 4'h1;
      started_q <= 1'b1;
    end
  end

  always_ff @(negedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_q <= 1'b0;
      ok_q <= 1'b0;
      hold_q <= '0;
    end else begin
      if (!started_q) begin
        tgl_q <= ~tgl_q;
      end
      ok_q <= word_end;
      if (word_end) begin
        hold_q <= in_d;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge link_clr) begin
    if (link_clr) begin
      rcnt_q <= '0;
      st_q <= '0;
      so_q <= 1'b0;
    end else begin
      if (rcnt_q != gdsp_pkg::RISE_STATUS) begin
        rcnt_q <= rcnt_q + 5'h01;
      end
      if (rcnt_q == 5'h00) begin
        so_q <= snap_q[gdsp_pkg::WORD_W-1];
        st_q <= {snap_q[gdsp_pkg::WORD_W-2:0], 1'b0};
      end else if (rcnt_q != gdsp_pkg::RISE_STATUS) begin
        so_q <= st_q[gdsp_pkg::WORD_W-1];
        st_q <= {st_q[gdsp_pkg::WORD_W-2:0], 1'b0};
      end else begin
        // earlier received bits follow in order
        so_q <= in_q[gdsp_pkg::WORD_W-1];
      end
    end
  end

  assign so_o = so_q;
  assign so_oe_o = ~cs_n_i;

  // ---------------- core side, on clk_i ----------------
  logic [2:0] sync_q;
  logic cs_s;
  logic tgl_s;
  logic ok_s;
  logic cs_prev_q;
  logic tgl_seen_q;
  logic cs_rise;
  logic commit;
  gdsp_pkg::gdsp_word_t word;
  gdsp_pkg::gdsp_pwr_t pwr;

  gdsp_sync #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i({~cs_n_i, tgl_q, ok_q}),
    .rst_val_i(3'h0),
    .q_o(sync_q)
  );

  assign cs_s = ~sync_q[2];
  assign tgl_s = sync_q[1];
  assign ok_s = sync_q[0];
  assign cs_rise = cs_s & ~cs_prev_q;
  // commit at select rising; whole words only
  assign commit = cs_rise & ok_s & (tgl_s != tgl_seen_q);
  assign word = gdsp_pkg::gdsp_word_t'(hold_q);
  assign pwr = gdsp_pkg::gdsp_pwr_t'(word.data);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_prev_q <= 1'b1;
      tgl_seen_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      if (cs_rise) begin
        tgl_seen_q <= tgl_s;
      end
    end
  end

  logic is_pwr;
  logic is_fwd;
  logic pwr_ok;
  assign is_pwr = commit & (word.addr == gdsp_pkg::ADDR_PWR);
  assign is_fwd = commit & (word.addr != gdsp_pkg::ADDR_PWR)
    & (word.addr != gdsp_pkg::ADDR_UNUSED) & (word.addr != gdsp_pkg::ADDR_TEST);
  assign pwr_ok = is_pwr & ~pwr.null_command_flag & (pwr.mbz == gdsp_pkg::MBZ_ZERO);

  gdsp_pkg::gdsp_word_t wr_q;
  logic wr_valid_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q <= '0;
      wr_valid_q <= 1'b0;
    end else begin
      wr_valid_q <= is_fwd;
      if (is_fwd) begin
        wr_q <= word;
      end
    end
  end
  assign wr_o = wr_q;
  assign wr_valid_o = wr_valid_q;

  // driver enables, slowdown and frequency select; write-only, no readback path
  logic en0_q;
  logic en1_q;
  logic slow_q;
  logic fsel_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en0_q <= gdsp_pkg::EN_RESET;
      en1_q <= gdsp_pkg::EN_RESET;
      slow_q <= 1'b0;
      fsel_q <= 1'b0;
    end else if (pwr_ok) begin
      en0_q <= pwr.gauge0_driver_enable;
      en1_q <= pwr.gauge1_driver_enable;
      slow_q <= pwr.osc_slowdown;
      fsel_q <= pwr.cal_frequency_select;
    end
  end
  assign gauge0_driver_enable_o = en0_q;
  assign gauge1_driver_enable_o = en1_q;
  assign standby_o = ~en0_q & ~en1_q;
  assign osc_slowdown_o = slow_q;
  assign cal_frequency_select_o = fsel_q;

  // ---------------- calibration ----------------
  gdsp_pkg::gdsp_cal_state_t cal_q;
  gdsp_pkg::gdsp_cal_state_t cal_d;
  logic [gdsp_pkg::CNT_W-1:0] ccnt_q;
  logic fault_q;
  logic [gdsp_pkg::CNT_W-1:0] trim_q;
  logic cal_allow;
  logic cal_start;
  logic [gdsp_pkg::CNT_W-1:0] lo;
  logic [gdsp_pkg::CNT_W-1:0] hi;
  logic cal_end;
  logic cal_bad;

  assign cal_allow = (~pwr.gauge0_driver_enable | ~status_i[gdsp_pkg::ST_MOVING0])
    & (~pwr.gauge1_driver_enable | ~status_i[gdsp_pkg::ST_MOVING1]);
  assign cal_start = pwr_ok & pwr.cal_enable & cal_allow & (cal_q == gdsp_pkg::CAL_IDLE);
  assign lo = slow_q ? CAL_SLOW_LO : CAL_LO;
  assign hi = slow_q ? CAL_SLOW_HI : CAL_HI;
  assign cal_end = (cal_q == gdsp_pkg::CAL_MEAS) & cs_s;
  assign cal_bad = (ccnt_q < lo) | (ccnt_q > hi);

  always_comb begin
    cal_d = cal_q;
    case (cal_q)
      gdsp_pkg::CAL_IDLE: begin
        if (cal_start) begin
          cal_d = gdsp_pkg::CAL_ARM;
        end
      end
      gdsp_pkg::CAL_ARM: begin
        if (!cs_s) begin
          cal_d = gdsp_pkg::CAL_MEAS;
        end else if (ccnt_q == CAL_WAIT) begin
          cal_d = gdsp_pkg::CAL_IDLE;
        end
      end
      gdsp_pkg::CAL_MEAS: begin
        if (cs_s) begin
          cal_d = gdsp_pkg::CAL_IDLE;
        end
      end
      default: begin
        cal_d = gdsp_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cal_q <= gdsp_pkg::CAL_IDLE;
      ccnt_q <= '0;
      fault_q <= 1'b0;
      trim_q <= '0;
    end else begin
      cal_q <= cal_d;
      if (cal_d != cal_q) begin
        ccnt_q <= '0;
      end else if (ccnt_q != gdsp_pkg::CNT_MAX) begin
        ccnt_q <= ccnt_q + gdsp_pkg::CNT_ONE;
      end
      if (cal_start) begin
        fault_q <= 1'b0;
      end else if ((cal_q == gdsp_pkg::CAL_ARM) && (cal_d == gdsp_pkg::CAL_IDLE)) begin
        fault_q <= 1'b1;
      end else if (cal_end) begin
        fault_q <= cal_bad;
        if (!cal_bad) begin
          trim_q <= ccnt_q;
        end
      end
    end
  end
  assign cal_busy_o = (cal_q != gdsp_pkg::CAL_IDLE);
  assign cal_fault_status_o = fault_q;
  assign osc_trim_o = trim_q;

  // status snapshot, frozen while selected
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      snap_q <= '0;
    end else if (cs_s) begin
      snap_q <= status_i;
      snap_q[gdsp_pkg::ST_CAL_FAULT] <= fault_q;
    end
  end

  // ---------------- assertions ----------------
  property p_commit_en;
    @(posedge clk_i) disable iff (!reset_n_i)
      pwr_ok |=> (en0_q == $past(pwr.gauge0_driver_enable))
        && (en1_q == $past(pwr.gauge1_driver_enable));
  endproperty
  a_commit_en: assert property (p_commit_en) else $error("enable not taken");

  property p_short;
    @(posedge clk_i) disable iff (!reset_n_i)
      (cs_rise && !ok_s) |=> !wr_valid_o;
  endproperty
  a_short: assert property (p_short) else $error("partial word accepted");

  property p_standby;
    @(posedge clk_i) disable iff (!reset_n_i)
      (pwr_ok && !pwr.gauge0_driver_enable && !pwr.gauge1_driver_enable) |=> standby_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_null;
    @(posedge clk_i) disable iff (!reset_n_i)
      (is_pwr && pwr.null_command_flag) |=> $stable(en0_q) && $stable(en1_q)
        && $stable(slow_q) && !cal_busy_o;
  endproperty
  a_null: assert property (p_null) else $error("null command changed state");

  property p_mbz;
    @(posedge clk_i) disable iff (!reset_n_i)
      (is_pwr && pwr.mbz != gdsp_pkg::MBZ_ZERO) |=> $stable(en0_q) && $stable(fsel_q);
  endproperty
  a_mbz: assert property (p_mbz) else $error("invalid word applied");

  property p_unused;
    @(posedge clk_i) disable iff (!reset_n_i)
      (commit && word.addr[2:1] == 2'b11) |=> !wr_valid_o && $stable(en0_q);
  endproperty
  a_unused: assert property (p_unused) else $error("unused code acted on");

  property p_fwd;
    @(posedge clk_i) disable iff (!reset_n_i)
      (commit && word.addr == gdsp_pkg::ADDR_VEL) |=> wr_valid_o
        && wr_o.addr == gdsp_pkg::ADDR_VEL ##1 !wr_valid_o;
  endproperty
  a_fwd: assert property (p_fwd) else $error("register write not forwarded");

  property p_cal_block;
    @(posedge clk_i) disable iff (!reset_n_i)
      (pwr_ok && pwr.cal_enable && !cal_allow) |=> cal_q == gdsp_pkg::CAL_IDLE;
  endproperty
  a_cal_block: assert property (p_cal_block) else $error("calibration while moving");

  property p_cal_fault;
    @(posedge clk_i) disable iff (!reset_n_i)
      (cal_end && (ccnt_q < lo)) |=> cal_fault_status_o && !cal_busy_o;
  endproperty
  a_cal_fault: assert property (p_cal_fault) else $error("short pulse not flagged");

  property p_so_first;
    @(posedge sclk_i) disable iff (link_clr)
      (rcnt_q == 5'h00) |=> so_q == $past(snap_q[gdsp_pkg::WORD_W-1]);
  endproperty
  a_so_first: assert property (p_so_first) else $error("status not sent first");

endmodule // gdsp_port

/* gdsp_pkg.sv */
// shared constants and types of the gauge driver serial command port
package gdsp_pkg;

  localparam int WORD_W = 16;
  localparam int DATA_W = 13;
  localparam int CNT_W = 12;

  // word address field codes
  localparam logic [2:0] ADDR_PWR = 3'h0;
  localparam logic [2:0] ADDR_VEL = 3'h1;
  localparam logic [2:0] ADDR_POS0 = 3'h2;
  localparam logic [2:0] ADDR_POS1 = 3'h3;
  localparam logic [2:0] ADDR_RTZ = 3'h4;
  localparam logic [2:0] ADDR_RTZ_CFG = 3'h5;
  localparam logic [2:0] ADDR_UNUSED = 3'h6;
  localparam logic [2:0] ADDR_TEST = 3'h7;

  // status word bit positions
  localparam int ST_MOVING0 = 4;
  localparam int ST_MOVING1 = 5;
  localparam int ST_CAL_FAULT = 7;

  // bit counter values
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [4:0] RISE_STATUS = 5'h10;

  // power/enable/calibration defaults
  localparam logic EN_RESET = 1'b0;
  localparam logic [6:0] MBZ_ZERO = 7'h00;

  // calibration timing
  localparam int CLK_MHZ = 100;
  localparam int CAL_PULSE_NS = 8000;
  localparam int CAL_SLOW_PULSE_NS = 12000;
  localparam int CAL_WAIT_NS = 2000;
  localparam int CAL_TOL_PCT = 10;
  localparam int CAL_CYC = CAL_PULSE_NS * CLK_MHZ / 1000;
  localparam int CAL_SLOW_CYC = CAL_SLOW_PULSE_NS * CLK_MHZ / 1000;
  localparam int CAL_WAIT_CYC = CAL_WAIT_NS * CLK_MHZ / 1000;
  localparam logic [CNT_W-1:0] CAL_LO = CNT_W'(CAL_CYC * (100 - CAL_TOL_PCT) / 100);
  localparam logic [CNT_W-1:0] CAL_HI = CNT_W'(CAL_CYC * (100 + CAL_TOL_PCT) / 100);
  localparam logic [CNT_W-1:0] CAL_SLOW_LO =
    CNT_W'(CAL_SLOW_CYC * (100 - CAL_TOL_PCT) / 100);
  localparam logic [CNT_W-1:0] CAL_SLOW_HI =
    CNT_W'(CAL_SLOW_CYC * (100 + CAL_TOL_PCT) / 100);
  localparam logic [CNT_W-1:0] CAL_WAIT = CNT_W'(CAL_WAIT_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;

  // one received word
  typedef struct packed {
    logic [2:0] addr;
    logic [DATA_W-1:0] data;
  } gdsp_word_t;

  // power/enable/calibration word layout
  typedef struct packed {
    logic null_command_flag;
    logic [6:0] mbz;
    logic cal_frequency_select;
    logic cal_enable;
    logic osc_slowdown;
    logic gauge1_driver_enable;
    logic gauge0_driver_enable;
  } gdsp_pwr_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_ARM = 2'b01,
    CAL_MEAS = 2'b10
  } gdsp_cal_state_t;

endpackage

/* gdsp_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module gdsp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // reset takes zero; output xor restores the reset value, data path xor cancels it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i ^ rst_val_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q ^ rst_val_i;

endmodule // gdsp_sync

/* gdsp_master.sv */
// bus master model that drives the serial command port
`timescale 1ns/1ps
module gdsp_master (
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  localparam int HALF_NS = 6;
  localparam int GAP_NS = 100;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // counted edges, msb first, clock low at select edges
  task automatic xfer(input logic [31:0] data, input int nbits, output logic [31:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    #48;
    for (int i = nbits - 1; i >= 0; i--) begin
      // data moves mid low phase, clear of the sampling fall
      #(HALF_NS / 2) si_o = data[i];
      #(HALF_NS / 2) sclk_o = 1'b1;
      #HALF_NS;
      rx = {rx[30:0], (so_oe_i === 1'b1) ? so_i : 1'bx};
      sclk_o = 1'b0;
    end
    #HALF_NS cs_n_o = 1'b1;
    // released data line shows the inverse level
    si_o = ~si_o;
    // select held high for the internal copy
    #GAP_NS;
  endtask

  // reference pulse with clock and data quiet
  task automatic pulse(input int len_ns);
    cs_n_o = 1'b0;
    #len_ns;
    cs_n_o = 1'b1;
    #GAP_NS;
  endtask
endmodule // gdsp_master

/* gauge_driver_spi_command_port_test.sv */
// self-checking bench for the serial command port
`timescale 1ns/1ps
module gauge_driver_spi_command_port_test;
  logic clk_i, reset_n_i, sclk, cs_n, si, so_o, so_oe_o;
  logic [15:0] status_i;
  gdsp_pkg::gdsp_word_t wr_o;
  logic wr_valid_o, en0, en1, standby, slow, fsel, busy, fault;
  logic [gdsp_pkg::CNT_W-1:0] trim;
  logic [31:0] rx;
  int bad_count, comparisons, pulses, p;

  gdsp_port i_gdsp_port (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .so_o(so_o), .so_oe_o(so_oe_o), .status_i(status_i), .wr_o(wr_o),
    .wr_valid_o(wr_valid_o), .gauge0_driver_enable_o(en0), .gauge1_driver_enable_o(en1),
    .standby_o(standby), .osc_slowdown_o(slow), .cal_frequency_select_o(fsel),
    .cal_busy_o(busy), .cal_fault_status_o(fault), .osc_trim_o(trim)
  );

  gdsp_master i_gdsp_master (
    .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_o), .so_oe_i(so_oe_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (wr_valid_o === 1'b1) pulses++;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [15:0] w);
    i_gdsp_master.xfer({16'h0000, w}, 16, rx);
  endtask

  task automatic set_status(input logic [15:0] v);
    @(negedge clk_i) status_i = v;
  endtask

  task automatic t_reset;
    check({so_oe_o, en1, en0, standby, busy, fault}, 32'h04);
  endtask

  task automatic t_enable;
    set_status(16'h5aa5);
    p = pulses;
    send(16'h0003);
    check(rx[15:0], 32'h5a25);
    check({en1, en0, standby}, 32'h6);
    check(pulses, p);
    send(16'h0001);
    check(rx[15:0], 32'h5a25);
    check({en1, en0, standby}, 32'h2);
  endtask

  task automatic t_addr;
    logic [15:0] w;
    for (int a = 1; a < 8; a++) begin
      w = {a[2:0], 13'h0a5a ^ 13'(a)};
      p = pulses;
      send(w);
      if (a < 6) begin
        check(pulses, p + 1);
        check(wr_o, w);
      end else begin
        check(pulses, p);
        check({en1, en0}, 32'h1);
      end
    end
  endtask

  task automatic t_refuse;
    p = pulses;
    send(16'h1000);
    check({en1, en0, standby}, 32'h2);
    send(16'h0020);
    check({en1, en0, standby}, 32'h2);
    i_gdsp_master.xfer(32'h0, 8, rx);
    check({en1, en0, standby}, 32'h2);
    i_gdsp_master.xfer(32'h0, 24, rx);
    check({en1, en0, standby}, 32'h2);
    check(pulses, p);
  endtask

  task automatic t_chain;
    p = pulses;
    i_gdsp_master.xfer(32'h2123_4321, 32, rx);
    check(rx, 32'h5a25_2123);
    check(pulses, p + 1);
    check(wr_o, 32'h4321);
  endtask

  task automatic t_standby;
    send(16'h0000);
    check({en1, en0, standby}, 32'h1);
  endtask

  task automatic t_cal;
    set_status(16'h0000);
    send(16'h0008);
    check(busy, 1);
    i_gdsp_master.pulse(8000);
    check({busy, fault, slow, fsel}, 32'h0);
    check({31'h0, trim >= gdsp_pkg::CAL_LO && trim <= gdsp_pkg::CAL_HI}, 1);
    send(16'h0008);
    i_gdsp_master.pulse(4000);
    check(fault, 1);
    send(16'h1000);
    check(rx[7], 1);
    send(16'h000c);
    i_gdsp_master.pulse(12000);
    check({fault, slow}, 32'h1);
    send(16'h0018);
    i_gdsp_master.pulse(8000);
    check({fault, slow, fsel}, 32'h1);
    set_status(16'h0010);
    send(16'h0009);
    check({busy, en0}, 32'h1);
    set_status(16'h0000);
  endtask

  initial begin
    reset_n_i = 1'b0;
    status_i = 16'h0000;
    bad_count = 0;
    comparisons = 0;
    pulses = 0;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i) reset_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_enable();
    t_addr();
    t_refuse();
    t_chain();
    t_standby();
    t_cal();
    report_and_stop();
  end

  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end
endmodule // gauge_driver_spi_command_port_test
